//--- logic/cold_load_pkg.sv
// Contract
// - Cold load: all idle, then start within 80 ms
// - Hold detection until max time or pickup loss
// - Detection feeds output and blocking matrices
// - Inrush needs rise plus second harmonic ratio
// - Zero harmonic threshold: inrush equals cold load
// - Inrush blocking starts at rise, before harmonics
// - After first cycle keep only with harmonics
// - Lingering between thresholds over 80 ms rejects
// - Idle threshold range 0.01 to 0.50 In
// - Start threshold range 0.30 to 10.00 In
// - Maximum time up to 300.00 s, 0.01 s
// - Harmonic threshold range 0 to 99 percent
`default_nettype none
package cold_load_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_IDLE = 8'h04;
    localparam logic [7:0] OFS_START = 8'h08;
    localparam logic [7:0] OFS_MAXT = 8'h0C;
    localparam logic [7:0] OFS_H2 = 8'h10;
    localparam logic [7:0] OFS_STATE = 8'h14;
    localparam logic [7:0] OFS_IRQ_ST = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
    // Field positions
    localparam int CTRL_EN_BIT = 0;
    localparam int EV_COLD_BIT = 0;
    localparam int EV_INRUSH_BIT = 1;
    localparam int EV_REJECT_BIT = 2;
    localparam int EV_N = 3;
    // Settings in 0.01 x In, 0.01 s and percent
    localparam logic [15:0] IDLE_MIN = 16'h0001;
    localparam logic [15:0] IDLE_MAX = 16'h0032;
    localparam logic [15:0] START_MIN = 16'h001E;
    localparam logic [15:0] START_MAX = 16'h03E8;
    localparam logic [15:0] MAXT_MIN = 16'h0001;
    localparam logic [15:0] MAXT_MAX = 16'h7530;
    localparam logic [15:0] H2_MAX = 16'h0063;
    // Reset values
    localparam logic [15:0] IDLE_RST = 16'h000A;
    localparam logic [15:0] START_RST = 16'h0078;
    localparam logic [15:0] MAXT_RST = 16'h0064;
    localparam logic [15:0] H2_RST = 16'h000F;
    localparam logic CTRL_EN_RST = 1'b1;
    // Timing
    localparam int CLK_HZ = 25000000;
    localparam int WINDOW_MS = 80;
    localparam int WINDOW_CYCLES = WINDOW_MS * (CLK_HZ / 1000);
    localparam int STEP_MS = 10;
    localparam int STEP_CYCLES = STEP_MS * (CLK_HZ / 1000);
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [1:0] {
        ST_WAIT_IDLE = 2'b00,
        ST_IDLE = 2'b01,
        ST_RISE = 2'b10,
        ST_ACTIVE = 2'b11
    } det_state_type;
endpackage
`default_nettype wire

//--- logic/phase_compare.sv
`timescale 1ns/1ps
`default_nettype none
module phase_compare #(
    parameter int MAG_W = 16,
    parameter int RATIO_W = 7
) (
    input wire logic [MAG_W-1:0] magnitude,
    input wire logic [RATIO_W-1:0] ratio,
    input wire logic [MAG_W-1:0] idle_th,
    input wire logic [MAG_W-1:0] start_th,
    input wire logic [RATIO_W-1:0] h2_th,
    output logic below_idle,
    output logic above_start,
    output logic h2_over
);
    // Threshold tests for one phase
    assign below_idle = magnitude < idle_th;
    assign above_start = magnitude > start_th;
    assign h2_over = ratio > h2_th;
endmodule
`default_nettype wire

//--- logic/cold_load_inrush_detector.sv
`timescale 1ns/1ps
`default_nettype none
module cold_load_inrush_detector #(
    parameter int WINDOW_CYCLES = cold_load_pkg::WINDOW_CYCLES,
    parameter int STEP_CYCLES = cold_load_pkg::STEP_CYCLES,
    parameter int MAG_W = 16,
    parameter int RATIO_W = 7
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic meas_strobe,
    input wire logic ratio_valid,
    input wire logic [MAG_W-1:0] mag_l1,
    input wire logic [MAG_W-1:0] mag_l2,
    input wire logic [MAG_W-1:0] mag_l3,
    input wire logic [RATIO_W-1:0] second_harmonic_ratio_l1,
    input wire logic [RATIO_W-1:0] second_harmonic_ratio_l2,
    input wire logic [RATIO_W-1:0] second_harmonic_ratio_l3,
    output logic cold_load_out_matrix,
    output logic cold_load_block_matrix,
    output logic inrush_out_matrix,
    output logic inrush_block_matrix,
    output logic irq,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int WIN_W = $clog2(WINDOW_CYCLES + 1);
    localparam int STEP_W = $clog2(STEP_CYCLES + 1);
    localparam int EV_N = cold_load_pkg::EV_N;

    // Clamp a written value into its accepted range
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction

    // Byte-lane merge of the low half word
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = d[7:0];
        end
        if (strb[1]) begin
            r[15:8] = d[15:8];
        end
        return r;
    endfunction

    logic en_r;
    logic [15:0] idle_r;
    logic [15:0] start_r;
    logic [15:0] maxt_r;
    logic [15:0] h2_r;
    logic [EV_N-1:0] irq_st_r;
    logic [EV_N-1:0] irq_mask_r;
    cold_load_pkg::det_state_type state_r;
    logic cold_r;
    logic inrush_r;
    logic h2_seen_r;
    logic [WIN_W-1:0] win_cnt_r;
    logic [STEP_W-1:0] step_cnt_r;
    logic [15:0] dur_cnt_r;
    logic irq_r;

    // Per-phase comparators, evaluated against the stored settings
    logic [2:0] below_idle;
    logic [2:0] above_start;
    logic [2:0] h2_over;
    logic [MAG_W-1:0] mag [3];
    logic [RATIO_W-1:0] ratio [3];
    assign mag[0] = mag_l1;
    assign mag[1] = mag_l2;
    assign mag[2] = mag_l3;
    assign ratio[0] = second_harmonic_ratio_l1;
    assign ratio[1] = second_harmonic_ratio_l2;
    assign ratio[2] = second_harmonic_ratio_l3;
    for (genvar p = 0; p < 3; p++) begin : g_phase
        phase_compare #(.MAG_W(MAG_W), .RATIO_W(RATIO_W)) u_cmp (
            .magnitude(mag[p]),
            .ratio(ratio[p]),
            .idle_th(idle_r[MAG_W-1:0]),
            .start_th(start_r[MAG_W-1:0]),
            .h2_th(h2_r[RATIO_W-1:0]),
            .below_idle(below_idle[p]),
            .above_start(above_start[p]),
            .h2_over(h2_over[p])
        );
    end

    // Qualified level decisions, only meaningful on a strobe
    wire all_idle = meas_strobe && (&below_idle);
    wire any_start = meas_strobe && (|above_start);
    wire none_start = meas_strobe && !(|above_start);
    wire left_idle = meas_strobe && !(&below_idle) && !(|above_start);
    wire h2_zero = (h2_r == 16'h0000);
    wire h2_any = |h2_over;
    wire win_end = (win_cnt_r == WIN_W'(WINDOW_CYCLES - 1));
    wire step_end = (step_cnt_r == STEP_W'(STEP_CYCLES - 1));
    wire dur_end = step_end && (dur_cnt_r == maxt_r - 16'h0001);
    wire harm_check = meas_strobe && ratio_valid;

    // Detection sequence; any disable drops back to waiting for idle
    cold_load_pkg::det_state_type state_nxt;
    logic ev_cold;
    logic ev_reject;
    always_comb begin
        state_nxt = state_r;
        ev_cold = 1'b0;
        ev_reject = 1'b0;
        case (state_r)
            cold_load_pkg::ST_WAIT_IDLE: begin
                if (all_idle) begin
                    state_nxt = cold_load_pkg::ST_IDLE;
                end
            end
            cold_load_pkg::ST_IDLE: begin
                if (any_start) begin
                    state_nxt = cold_load_pkg::ST_ACTIVE;
                    ev_cold = 1'b1;
                end else if (left_idle) begin
                    state_nxt = cold_load_pkg::ST_RISE;
                end
            end
            cold_load_pkg::ST_RISE: begin
                if (any_start) begin
                    state_nxt = cold_load_pkg::ST_ACTIVE;
                    ev_cold = 1'b1;
                end else if (all_idle) begin
                    state_nxt = cold_load_pkg::ST_IDLE;
                end else if (win_end) begin
                    state_nxt = cold_load_pkg::ST_WAIT_IDLE;
                    ev_reject = 1'b1;
                end
            end
            cold_load_pkg::ST_ACTIVE: begin
                if (none_start || dur_end) begin
                    state_nxt = cold_load_pkg::ST_WAIT_IDLE;
                end
            end
            default: begin
                state_nxt = cold_load_pkg::ST_WAIT_IDLE;
            end
        endcase
        if (!en_r) begin
            state_nxt = cold_load_pkg::ST_WAIT_IDLE;
            ev_cold = 1'b0;
            ev_reject = 1'b0;
        end
    end

    // Inrush follows cold load at the rise, then harmonics decide
    wire active_nxt = (state_nxt == cold_load_pkg::ST_ACTIVE);
    logic inrush_nxt;
    always_comb begin
        inrush_nxt = 1'b0;
        if (ev_cold) begin
            inrush_nxt = 1'b1;
        end else if (active_nxt) begin
            inrush_nxt = inrush_r;
            if (harm_check && !h2_zero) begin
                inrush_nxt = inrush_r && h2_any;
            end
        end
    end

    // Detector registers; window counted in clock cycles, hold time in STEP_CYCLES steps
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            state_r <= cold_load_pkg::ST_WAIT_IDLE;
            cold_r <= 1'b0;
            inrush_r <= 1'b0;
            h2_seen_r <= 1'b0;
            win_cnt_r <= '0;
            step_cnt_r <= '0;
            dur_cnt_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cold_r <= active_nxt;
            inrush_r <= h2_zero ? active_nxt : inrush_nxt;
            h2_seen_r <= active_nxt && !ev_cold && (h2_seen_r || harm_check);
            win_cnt_r <= (state_r == cold_load_pkg::ST_RISE) ? win_cnt_r + 1'b1 : '0;
            step_cnt_r <= (!active_nxt || ev_cold || step_end) ? '0 : step_cnt_r + 1'b1;
            dur_cnt_r <= (!active_nxt || ev_cold) ? 16'h0000 :
                         step_end ? dur_cnt_r + 16'h0001 : dur_cnt_r;
        end
    end

    // Both matrices see the same registered detections
    assign cold_load_out_matrix = cold_r;
    assign cold_load_block_matrix = cold_r;
    assign inrush_out_matrix = inrush_r;
    assign inrush_block_matrix = inrush_r;
    assign irq = irq_r;

    // AXI4-Lite write: address and data may arrive in either order
    logic aw_got_r;
    logic w_got_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic awready_r;
    logic wready_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    wire aw_hs = s_axi_awvalid && awready_r;
    wire w_hs = s_axi_wvalid && wready_r;
    wire aw_have = aw_got_r || aw_hs;
    wire w_have = w_got_r || w_hs;
    wire do_write = aw_have && w_have && !bvalid_r;
    wire [7:0] wa = aw_hs ? s_axi_awaddr : waddr_r;
    wire [31:0] wd = w_hs ? s_axi_wdata : wdata_r;
    wire [3:0] ws = w_hs ? s_axi_wstrb : wstrb_r;
    wire wr_ctrl = do_write && (wa == cold_load_pkg::OFS_CTRL);
    wire wr_idle = do_write && (wa == cold_load_pkg::OFS_IDLE);
    wire wr_start = do_write && (wa == cold_load_pkg::OFS_START);
    wire wr_maxt = do_write && (wa == cold_load_pkg::OFS_MAXT);
    wire wr_h2 = do_write && (wa == cold_load_pkg::OFS_H2);
    wire wr_ist = do_write && (wa == cold_load_pkg::OFS_IRQ_ST);
    wire wr_imask = do_write && (wa == cold_load_pkg::OFS_IRQ_MASK);
    wire wr_hit = wr_ctrl || wr_idle || wr_start || wr_maxt || wr_h2 || wr_ist || wr_imask ||
                  (wa == cold_load_pkg::OFS_STATE);
    wire bdone = bvalid_r && s_axi_bready;
    wire bvalid_nxt = do_write || (bvalid_r && !s_axi_bready);
    wire aw_got_nxt = aw_have && !do_write;
    wire w_got_nxt = w_have && !do_write;

    // Write channel registers; ready drops while holding a half or a response
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            waddr_r <= 8'h00;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= cold_load_pkg::RESP_OKAY;
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            if (aw_hs) begin
                waddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            awready_r <= !aw_got_nxt && !bvalid_nxt;
            wready_r <= !w_got_nxt && !bvalid_nxt;
            bvalid_r <= bvalid_nxt;
            if (do_write) begin
                bresp_r <= wr_hit ? cold_load_pkg::RESP_OKAY : cold_load_pkg::RESP_SLVERR;
            end else if (bdone) begin
                bresp_r <= cold_load_pkg::RESP_OKAY;
            end
        end
    end
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Settings are clamped on write so a read shows what is in force
    wire [EV_N-1:0] events = {ev_reject, ev_cold && !h2_zero, ev_cold};
    wire [EV_N-1:0] irq_st_nxt = (irq_st_r & ~(wr_ist ? wd[EV_N-1:0] : '0)) | events;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            en_r <= cold_load_pkg::CTRL_EN_RST;
            idle_r <= cold_load_pkg::IDLE_RST;
            start_r <= cold_load_pkg::START_RST;
            maxt_r <= cold_load_pkg::MAXT_RST;
            h2_r <= cold_load_pkg::H2_RST;
            irq_st_r <= '0;
            irq_mask_r <= '0;
            irq_r <= 1'b0;
        end else begin
            if (wr_ctrl && ws[0]) begin
                en_r <= wd[cold_load_pkg::CTRL_EN_BIT];
            end
            if (wr_idle) begin
                idle_r <= clamp16(merge16(idle_r, wd, ws), cold_load_pkg::IDLE_MIN,
                                  cold_load_pkg::IDLE_MAX);
            end
            if (wr_start) begin
                start_r <= clamp16(merge16(start_r, wd, ws), cold_load_pkg::START_MIN,
                                   cold_load_pkg::START_MAX);
            end
            if (wr_maxt) begin
                maxt_r <= clamp16(merge16(maxt_r, wd, ws), cold_load_pkg::MAXT_MIN,
                                  cold_load_pkg::MAXT_MAX);
            end
            if (wr_h2) begin
                h2_r <= clamp16(merge16(h2_r, wd, ws), 16'h0000, cold_load_pkg::H2_MAX);
            end
            if (wr_imask && ws[0]) begin
                irq_mask_r <= wd[EV_N-1:0];
            end
            irq_st_r <= irq_st_nxt; // Set wins over the clear
            irq_r <= |(irq_st_nxt & (wr_imask && ws[0] ? wd[EV_N-1:0] : irq_mask_r));
        end
    end

    // AXI4-Lite read, one beat at a time
    logic arready_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire ar_hs = s_axi_arvalid && arready_r;
    wire rvalid_nxt = ar_hs || (rvalid_r && !s_axi_rready);
    logic [31:0] rd_mux;
    logic rd_hit;
    always_comb begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            cold_load_pkg::OFS_CTRL: rd_mux[cold_load_pkg::CTRL_EN_BIT] = en_r;
            cold_load_pkg::OFS_IDLE: rd_mux[15:0] = idle_r;
            cold_load_pkg::OFS_START: rd_mux[15:0] = start_r;
            cold_load_pkg::OFS_MAXT: rd_mux[15:0] = maxt_r;
            cold_load_pkg::OFS_H2: rd_mux[15:0] = h2_r;
            cold_load_pkg::OFS_STATE: rd_mux[4:0] = {h2_seen_r, state_r, inrush_r, cold_r};
            cold_load_pkg::OFS_IRQ_ST: rd_mux[EV_N-1:0] = irq_st_r;
            cold_load_pkg::OFS_IRQ_MASK: rd_mux[EV_N-1:0] = irq_mask_r;
            default: rd_hit = 1'b0;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= cold_load_pkg::RESP_OKAY;
        end else begin
            arready_r <= !rvalid_nxt;
            rvalid_r <= rvalid_nxt;
            if (ar_hs) begin
                rdata_r <= rd_mux;
                rresp_r <= rd_hit ? cold_load_pkg::RESP_OKAY : cold_load_pkg::RESP_SLVERR;
            end
        end
    end
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    a_cold_from_rise: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ev_cold |=> cold_load_out_matrix && inrush_out_matrix)
        else $error("cold load rise did not raise detections");
    a_cold_release: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cold_r && (none_start || dur_end) |=> !cold_load_out_matrix)
        else $error("cold load held past release");
    a_matrix_same: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cold_load_out_matrix == cold_load_block_matrix &&
        inrush_out_matrix == inrush_block_matrix &&
        cold_load_out_matrix == (state_r == cold_load_pkg::ST_ACTIVE))
        else $error("matrix copies differ");
    a_inrush_sub: assert property (@(posedge clk_sys) disable iff (!reset_n)
        inrush_r |-> cold_r)
        else $error("inrush without cold load");
    a_inrush_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $stable(h2_r) && h2_zero && $past(h2_zero) |-> inrush_r == cold_r)
        else $error("zero threshold inrush differs");
    a_inrush_drop: assert property (@(posedge clk_sys) disable iff (!reset_n)
        cold_r && harm_check && !h2_zero && !h2_any && !ev_cold |=> !inrush_r)
        else $error("inrush kept without harmonics");
    a_window_end: assert property (@(posedge clk_sys) disable iff (!reset_n)
        state_r == cold_load_pkg::ST_RISE && win_end && !meas_strobe && en_r
        |=> state_r == cold_load_pkg::ST_WAIT_IDLE ##0 !cold_r)
        else $error("window expiry did not reject");
    a_rearm_idle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(cold_r) |-> state_r == cold_load_pkg::ST_WAIT_IDLE)
        else $error("rearmed without idle");
    a_ranges: assert property (@(posedge clk_sys) disable iff (!reset_n)
        idle_r >= cold_load_pkg::IDLE_MIN && idle_r <= cold_load_pkg::IDLE_MAX &&
        start_r >= cold_load_pkg::START_MIN && maxt_r <= cold_load_pkg::MAXT_MAX &&
        h2_r <= cold_load_pkg::H2_MAX)
        else $error("setting out of range");
    a_strobe_only: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !meas_strobe && state_r == cold_load_pkg::ST_IDLE |=> !cold_r)
        else $error("detection without strobe");
endmodule
`default_nettype wire

//--- sim/matrix_sink.sv
`timescale 1ns/1ps
`default_nettype none
module matrix_sink (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cold_load_out_matrix,
    input wire logic cold_load_block_matrix,
    input wire logic inrush_out_matrix,
    input wire logic inrush_block_matrix,
    output logic group_sel_r,
    output logic stage_block_r
);
    // Virtual output picks the coarse setting group, blocking matrix holds stages off
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            group_sel_r <= 1'b0;
            stage_block_r <= 1'b0;
        end else begin
            group_sel_r <= cold_load_out_matrix | inrush_out_matrix;
            stage_block_r <= cold_load_block_matrix | inrush_block_matrix;
        end
    end
endmodule
`default_nettype wire

//--- sim/cold_load_inrush_detector_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cold_load_inrush_detector_tb;
    logic clk_sys, reset_n, meas_strobe, ratio_valid;
    logic [15:0] mag_l1, mag_l2, mag_l3;
    logic [6:0] ratio_l1, ratio_l2, ratio_l3;
    logic cold_out, cold_blk, inr_out, inr_blk, irq, group_sel, stage_block;
    logic [7:0] awaddr, araddr;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    int errors, comparisons;
    // Short counts keep the 80 ms window and the hold timer cheap to simulate
    cold_load_inrush_detector #(.WINDOW_CYCLES(50), .STEP_CYCLES(10)) i_cold_load_inrush_detector (
        .clk_sys(clk_sys), .reset_n(reset_n), .meas_strobe(meas_strobe),
        .ratio_valid(ratio_valid), .mag_l1(mag_l1), .mag_l2(mag_l2), .mag_l3(mag_l3),
        .second_harmonic_ratio_l1(ratio_l1), .second_harmonic_ratio_l2(ratio_l2),
        .second_harmonic_ratio_l3(ratio_l3), .cold_load_out_matrix(cold_out),
        .cold_load_block_matrix(cold_blk), .inrush_out_matrix(inr_out),
        .inrush_block_matrix(inr_blk), .irq(irq), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    matrix_sink i_matrix_sink (.clk_sys(clk_sys), .reset_n(reset_n),
        .cold_load_out_matrix(cold_out), .cold_load_block_matrix(cold_blk),
        .inrush_out_matrix(inr_out), .inrush_block_matrix(inr_blk),
        .group_sel_r(group_sel), .stage_block_r(stage_block));
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Both halves offered together; each dropped at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        cmp({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        cmp(rdata, ed);
        cmp({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask
    // One strobe; l1 alone, l2 and l3 together; harmonic only on l3
    task automatic meas(input logic [15:0] m1, input logic [15:0] m2, input logic [6:0] r,
                        input logic rv);
        @(posedge clk_sys);
        mag_l1 <= m1;
        mag_l2 <= m2;
        mag_l3 <= m2;
        ratio_l3 <= r;
        ratio_valid <= rv;
        meas_strobe <= 1'b1;
        @(posedge clk_sys);
        meas_strobe <= 1'b0;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic det(input logic c, input logic i);
        cmp({30'h0, cold_out, cold_blk}, {30'h0, c, c});
        cmp({30'h0, inr_out, inr_blk}, {30'h0, i, i});
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        report_and_stop;
    end
    initial begin
        {reset_n, meas_strobe, ratio_valid, awvalid, wvalid, bready, arvalid, rready} = 8'h00;
        {mag_l1, mag_l2, mag_l3} = 48'h0;
        {ratio_l1, ratio_l2, ratio_l3} = 21'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        errors = 0;
        comparisons = 0;
        repeat (10) @(posedge clk_sys);
        reset_n <= 1'b1;
        rd(cold_load_pkg::OFS_CTRL, 32'h1, 2'b00);
        rd(cold_load_pkg::OFS_IRQ_MASK, 32'h0, 2'b00);
        rd(8'h20, 32'h0, 2'b10);
        wr(8'h24, 32'h1, 2'b10);
        wr(cold_load_pkg::OFS_STATE, 32'hFF, 2'b00);
        rd(cold_load_pkg::OFS_STATE, 32'h0, 2'b00);
        wr(cold_load_pkg::OFS_IDLE, 32'h40, 2'b00);
        rd(cold_load_pkg::OFS_IDLE, 32'h32, 2'b00);
        wr(cold_load_pkg::OFS_IDLE, 32'h0A, 2'b00);
        wr(cold_load_pkg::OFS_START, 32'h05, 2'b00);
        rd(cold_load_pkg::OFS_START, 32'h1E, 2'b00);
        wr(cold_load_pkg::OFS_START, 32'h78, 2'b00);
        wr(cold_load_pkg::OFS_MAXT, 32'h9999, 2'b00);
        rd(cold_load_pkg::OFS_MAXT, 32'h7530, 2'b00);
        wr(cold_load_pkg::OFS_MAXT, 32'h05, 2'b00);
        wr(cold_load_pkg::OFS_H2, 32'h7F, 2'b00);
        rd(cold_load_pkg::OFS_H2, 32'h63, 2'b00);
        wr(cold_load_pkg::OFS_H2, 32'h0F, 2'b00);
        wr(cold_load_pkg::OFS_IRQ_MASK, 32'h3, 2'b00);
        $display("test registers done");
        meas(16'd5, 16'd5, 7'd0, 1'b0);
        meas(16'd200, 16'd5, 7'd30, 1'b0);
        det(1'b1, 1'b1);
        cmp({31'h0, irq}, 32'h1);
        meas(16'd200, 16'd5, 7'd30, 1'b1);
        det(1'b1, 1'b1);
        cmp({30'h0, group_sel, stage_block}, 32'h3);
        repeat (30) @(posedge clk_sys);
        #1;
        det(1'b1, 1'b1);
        repeat (20) @(posedge clk_sys);
        #1;
        det(1'b0, 1'b0);
        rd(cold_load_pkg::OFS_IRQ_ST, 32'h3, 2'b00);
        wr(cold_load_pkg::OFS_IRQ_ST, 32'h3, 2'b00);
        cmp({31'h0, irq}, 32'h0);
        meas(16'd200, 16'd5, 7'd30, 1'b1);
        det(1'b0, 1'b0);
        $display("test timed hold done");
        meas(16'd5, 16'd5, 7'd0, 1'b0);
        meas(16'd5, 16'd200, 7'd0, 1'b0);
        det(1'b1, 1'b1);
        meas(16'd5, 16'd200, 7'd5, 1'b1);
        det(1'b1, 1'b0);
        meas(16'd50, 16'd5, 7'd0, 1'b1);
        det(1'b0, 1'b0);
        wr(cold_load_pkg::OFS_IRQ_ST, 32'h3, 2'b00);
        $display("test release done");
        meas(16'd5, 16'd5, 7'd0, 1'b0);
        meas(16'd50, 16'd5, 7'd0, 1'b0);
        repeat (60) @(posedge clk_sys);
        meas(16'd200, 16'd5, 7'd0, 1'b0);
        det(1'b0, 1'b0);
        rd(cold_load_pkg::OFS_IRQ_ST, 32'h4, 2'b00);
        cmp({31'h0, irq}, 32'h0);
        wr(cold_load_pkg::OFS_IRQ_MASK, 32'h7, 2'b00);
        cmp({31'h0, irq}, 32'h1);
        wr(cold_load_pkg::OFS_IRQ_ST, 32'h4, 2'b00);
        cmp({31'h0, irq}, 32'h0);
        $display("test reject done");
        wr(cold_load_pkg::OFS_H2, 32'h0, 2'b00);
        meas(16'd5, 16'd5, 7'd0, 1'b0);
        meas(16'd50, 16'd5, 7'd0, 1'b0);
        meas(16'd200, 16'd5, 7'd0, 1'b1);
        det(1'b1, 1'b1);
        meas(16'd200, 16'd5, 7'd0, 1'b1);
        det(1'b1, 1'b1);
        rd(cold_load_pkg::OFS_IRQ_ST, 32'h1, 2'b00);
        wr(cold_load_pkg::OFS_CTRL, 32'h0, 2'b00);
        repeat (2) @(posedge clk_sys);
        #1;
        det(1'b0, 1'b0);
        $display("test zero harmonic done");
        report_and_stop;
    end
endmodule
`default_nettype wire
